/* File: core/wmei_edge_group.sv */
// Edge detection and sticky latching for one group of eight sources.
`timescale 1ns/1ns
`default_nettype none
`include "wmei_regs.svh"

module wmei_edge_group (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  // Sources, edge selects and write-one-to-clear strobes
  input  wire logic [7:0]  source_i,
  input  wire logic [15:0] select_i,
  input  wire logic [7:0]  clear_i,
  // Latched sources
  output logic      [7:0]  pending_o
);

  logic [7:0]  prev_source;
  logic [15:0] prev_select;
  logic [7:0]  edge_seen;

  // Level that a single-direction edge settles into.
  function automatic logic edge_level(input logic [1:0] sel,
                                      input logic       x);
    case (sel)
      `WMEI_EDGE_FALL: edge_level = ~x;
      `WMEI_EDGE_RISE: edge_level = x;
      default:         edge_level = 1'b0;
    endcase
  endfunction

  // The old select is compared with the old level, so a select change can
  // itself look like an edge; firmware clears such events.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (select_i[2*i +: 2] == `WMEI_EDGE_EITHER) begin
        edge_seen[i] = source_i[i] ^ prev_source[i];
      end else begin
        edge_seen[i] = edge_level(select_i[2*i +: 2], source_i[i]) &
                       ~edge_level(prev_select[2*i +: 2], prev_source[i]);
      end
    end
  end

  // Raw pin edges, with no filter: noise rejection is external.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_source <= 8'h00;
      prev_select <= 16'h0000;
    end else begin
      prev_source <= source_i;
      prev_select <= select_i;
    end
  end

  // A new edge wins over a clear in the same cycle.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pending_o <= 8'h00;
    end else begin
      pending_o <= (pending_o & ~clear_i) | edge_seen;
    end
  end

endmodule
`default_nettype wire

/* File: core/wmei_top.sv */
// Wake masks, hibernation timer, edge selects, power-fail flag, serial IRQ.
//
// Behaviour
// - A mask bit of one blocks its wake source from interrupting the core.
// - The infrared wake input is edge-detected with no digital filter.
// - Hibernation timer is one eight-bit binary down-counter register.
// - Each hibernation count step lasts thirty seconds.
// - At zero the timer stops, holds zero and raises a wake event.
// - The hibernation timer advances from the 32 kHz low-speed clock.
// - Writing a non-zero value loads it and starts the count-down.
// - Groups zero, one, two drive core external interrupts two, three, four.
// - Two-bit edge field per source: fall, rise, either, reserved.
// - Changing an edge field may latch a spurious wake event.
// - Power-good flag sets when main power ok deasserts, never while asserted.
// - Power-good flag drives the core power-fail interrupt directly.
// - Power-good flag is readable and clears only on a one written to D0.
// - Core can raise a request on the host serial IRQ stream.
// - Select field 7:4 picks IRQ1 to IRQ15; zero means no interrupt.
// - Enable bit 3 must be one for any serial interrupt.
// - Request bit 2 must be one to assert the selected serial IRQ.
// - With mapping disabled the IRQ level shows its default asserted state.
`timescale 1ns/1ns
`default_nettype none
`include "wmei_regs.svh"

module wmei_top #(
  parameter int unsigned HIB_STEP_TICKS = `WMEI_HIB_STEP_TICKS
) (
  // Clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    arst_n_i,
  // Core memory-mapped register port
  input  wire logic [15:0]             bus_addr_i,
  input  wire logic [7:0]              bus_wdata_i,
  input  wire logic                    bus_write_i,
  input  wire logic                    bus_read_i,
  output logic      [7:0]              bus_rdata_o,
  // Selectable wake sources, group n in bits 8n+7:8n
  input  wire logic [23:0]             selectable_source_i,
  // Group zero mask and source clear, held outside this block
  input  wire logic [7:0]              wake_mask_group0_i,
  input  wire logic [7:0]              wake_clear_group0_i,
  output logic      [7:0]              wake_pending_group0_o,
  // Latched flags of sources whose source registers live elsewhere
  input  wire logic [2:0]              wake_misc_flags_i,
  input  wire logic [7:0]              wake_lpc_gpio_flags_i,
  output logic                         wake_misc_o,
  output logic                         wake_lpc_gpio_o,
  // Hibernation timer
  input  wire logic                    slow_clock_tick_i,
  output logic                         hibernation_wake_o,
  // Power supervision
  input  wire logic                    main_power_ok_input_i,
  // Interrupt outputs
  output wmei_pkg::wmei_core_irq_s     core_irq_o,
  output wmei_pkg::wmei_sirq_s         serial_irq_o
);

  localparam logic [19:0] STEP_LAST = 20'(HIB_STEP_TICKS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [7:0]  serial_irq_control;
  logic [7:0]  wake_mask_lpc_gpio_group;
  logic [7:0]  wake_mask_select_group1;
  logic [7:0]  wake_mask_select_group2;
  logic [7:0]  wake_mask_misc_sources;
  logic [15:0] edge_select_group0;
  logic [15:0] edge_select_group1;
  logic [15:0] edge_select_group2;
  logic [7:0]  hibernation_countdown;
  logic [19:0] hib_prescale;
  logic        power_good_loss_flag_bit;
  logic        power_ok_prev;
  logic [7:0]  pending_g1;
  logic [7:0]  pending_g2;
  logic [7:0]  clear_g1;
  logic [7:0]  clear_g2;
  logic        hib_write;
  logic        hib_step;
  logic        next_irq_level;

  function automatic logic hit(input logic [15:0] addr,
                               input logic [15:0] reg_addr);
    hit = addr == reg_addr;
  endfunction

  assign hib_write = bus_write_i && hit(bus_addr_i, `WMEI_ADDR_HIB);
  assign clear_g1  = (bus_write_i && hit(bus_addr_i, `WMEI_ADDR_SRC_G1)) ?
                     bus_wdata_i : 8'h00;
  assign clear_g2  = (bus_write_i && hit(bus_addr_i, `WMEI_ADDR_SRC_G2)) ?
                     bus_wdata_i : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection per group.
  wmei_edge_group u_group0 (
    .clock_i   (clock_i),
    .arst_n_i  (arst_n_i),
    .source_i  (selectable_source_i[7:0]),
    .select_i  (edge_select_group0),
    .clear_i   (wake_clear_group0_i),
    .pending_o (wake_pending_group0_o)
  );

  wmei_edge_group u_group1 (
    .clock_i   (clock_i),
    .arst_n_i  (arst_n_i),
    .source_i  (selectable_source_i[15:8]),
    .select_i  (edge_select_group1),
    .clear_i   (clear_g1),
    .pending_o (pending_g1)
  );

  wmei_edge_group u_group2 (
    .clock_i   (clock_i),
    .arst_n_i  (arst_n_i),
    .source_i  (selectable_source_i[23:16]),
    .select_i  (edge_select_group2),
    .clear_i   (clear_g2),
    .pending_o (pending_g2)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Plain read/write registers.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      serial_irq_control       <= `WMEI_RESET_VALUE;
      wake_mask_lpc_gpio_group <= `WMEI_RESET_VALUE;
      wake_mask_select_group1  <= `WMEI_RESET_VALUE;
      wake_mask_select_group2  <= `WMEI_RESET_VALUE;
      wake_mask_misc_sources   <= `WMEI_RESET_VALUE;
      edge_select_group0       <= {2{`WMEI_RESET_VALUE}};
      edge_select_group1       <= {2{`WMEI_RESET_VALUE}};
      edge_select_group2       <= {2{`WMEI_RESET_VALUE}};
    end else if (bus_write_i) begin
      case (bus_addr_i)
        `WMEI_ADDR_SIRQ:      serial_irq_control <=
                                bus_wdata_i & `WMEI_SIRQ_WRITABLE;
        `WMEI_ADDR_MASK_LPC:  wake_mask_lpc_gpio_group <= bus_wdata_i;
        `WMEI_ADDR_MASK_G1:   wake_mask_select_group1 <= bus_wdata_i;
        `WMEI_ADDR_MASK_G2:   wake_mask_select_group2 <= bus_wdata_i;
        `WMEI_ADDR_MASK_MISC: wake_mask_misc_sources <=
                                bus_wdata_i & `WMEI_MASK_MISC_WRITABLE;
        `WMEI_ADDR_ES0_LO:    edge_select_group0[7:0] <= bus_wdata_i;
        `WMEI_ADDR_ES0_HI:    edge_select_group0[15:8] <= bus_wdata_i;
        `WMEI_ADDR_ES1_LO:    edge_select_group1[7:0] <= bus_wdata_i;
        `WMEI_ADDR_ES1_HI:    edge_select_group1[15:8] <= bus_wdata_i;
        `WMEI_ADDR_ES2_LO:    edge_select_group2[7:0] <= bus_wdata_i;
        `WMEI_ADDR_ES2_HI:    edge_select_group2[15:8] <= bus_wdata_i;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_rdata_o <= 8'h00;
    end else if (!bus_read_i) begin
      bus_rdata_o <= 8'h00;
    end else begin
      case (bus_addr_i)
        `WMEI_ADDR_SIRQ:      bus_rdata_o <= serial_irq_control;
        `WMEI_ADDR_MASK_LPC:  bus_rdata_o <= wake_mask_lpc_gpio_group;
        `WMEI_ADDR_MASK_G1:   bus_rdata_o <= wake_mask_select_group1;
        `WMEI_ADDR_MASK_G2:   bus_rdata_o <= wake_mask_select_group2;
        `WMEI_ADDR_MASK_MISC: bus_rdata_o <= wake_mask_misc_sources;
        `WMEI_ADDR_ES0_LO:    bus_rdata_o <= edge_select_group0[7:0];
        `WMEI_ADDR_ES0_HI:    bus_rdata_o <= edge_select_group0[15:8];
        `WMEI_ADDR_ES1_LO:    bus_rdata_o <= edge_select_group1[7:0];
        `WMEI_ADDR_ES1_HI:    bus_rdata_o <= edge_select_group1[15:8];
        `WMEI_ADDR_ES2_LO:    bus_rdata_o <= edge_select_group2[7:0];
        `WMEI_ADDR_ES2_HI:    bus_rdata_o <= edge_select_group2[15:8];
        `WMEI_ADDR_SRC_G1:    bus_rdata_o <= pending_g1;
        `WMEI_ADDR_SRC_G2:    bus_rdata_o <= pending_g2;
        `WMEI_ADDR_PWR_IRQ:   bus_rdata_o <=
                                {7'h00, power_good_loss_flag_bit};
        `WMEI_ADDR_HIB:       bus_rdata_o <= hibernation_countdown;
        default:              bus_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hibernation timer. The prescaler counts low-speed ticks, so the count
  // rate does not depend on the core clock frequency.
  assign hib_step = slow_clock_tick_i && (hib_prescale == STEP_LAST);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hib_prescale <= 20'h00000;
    end else if (hib_write || hibernation_countdown == 8'h00) begin
      hib_prescale <= 20'h00000;
    end else if (slow_clock_tick_i) begin
      hib_prescale <= hib_step ? 20'h00000 : hib_prescale + 20'h00001;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hibernation_countdown <= 8'h00;
      hibernation_wake_o    <= 1'b0;
    end else if (hib_write) begin
      hibernation_countdown <= bus_wdata_i;
      hibernation_wake_o    <= 1'b0;
    end else if (hib_step && hibernation_countdown != 8'h00) begin
      hibernation_countdown <= hibernation_countdown - 8'h01;
      hibernation_wake_o    <= hibernation_countdown == 8'h01;
    end else begin
      hibernation_wake_o    <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-good loss flag; a new loss wins over a clear in the same cycle.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      power_ok_prev            <= 1'b1;
      power_good_loss_flag_bit <= 1'b0;
    end else begin
      power_ok_prev <= main_power_ok_input_i;
      if (power_ok_prev && !main_power_ok_input_i) begin
        power_good_loss_flag_bit <= 1'b1;
      end else if (bus_write_i && hit(bus_addr_i, `WMEI_ADDR_PWR_IRQ) &&
                   bus_wdata_i[`WMEI_PGI_BIT]) begin
        power_good_loss_flag_bit <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt outputs toward the core; all but power_fail are masked.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      core_irq_o      <= '0;
      wake_misc_o     <= 1'b0;
      wake_lpc_gpio_o <= 1'b0;
    end else begin
      core_irq_o.core_external_interrupt_two <=
        |(wake_pending_group0_o & ~wake_mask_group0_i);
      core_irq_o.core_external_interrupt_three <=
        |(pending_g1 & ~wake_mask_select_group1);
      core_irq_o.core_external_interrupt_four <=
        |(pending_g2 & ~wake_mask_select_group2);
      core_irq_o.power_fail <= power_good_loss_flag_bit;
      wake_misc_o <= |(wake_misc_flags_i & ~wake_mask_misc_sources[2:0]);
      wake_lpc_gpio_o <=
        |(wake_lpc_gpio_flags_i & ~wake_mask_lpc_gpio_group);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial IRQ request. A disabled mapping shows the default asserted level.
  always_comb begin
    if (!serial_irq_control[`WMEI_SIRQ_EN_BIT]) begin
      next_irq_level = 1'b1;
    end else if (serial_irq_control[`WMEI_SIRQ_SEL_MSB:`WMEI_SIRQ_SEL_LSB]
                 == `WMEI_SIRQ_NONE) begin
      next_irq_level = 1'b0;
    end else begin
      next_irq_level = serial_irq_control[`WMEI_SIRQ_REQ_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      serial_irq_o <= '0;
    end else begin
      serial_irq_o.irq_select <=
        serial_irq_control[`WMEI_SIRQ_SEL_MSB:`WMEI_SIRQ_SEL_LSB];
      serial_irq_o.enabled <= serial_irq_control[`WMEI_SIRQ_EN_BIT];
      serial_irq_o.request_asserted <= next_irq_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_mask_group1;
    @(posedge clock_i) disable iff (!arst_n_i)
      core_irq_o.core_external_interrupt_three ==
      $past(|(pending_g1 & ~wake_mask_select_group1));
  endproperty
  a_mask_group1: assert property (p_mask_group1)
    else $error("group one interrupt disagrees with masked sources");

  property p_masked_latch;
    @(posedge clock_i) disable iff (!arst_n_i)
      (pending_g2[0] && wake_mask_select_group2[0] &&
       pending_g2[7:1] == 7'h00) |=> !core_irq_o.core_external_interrupt_four;
  endproperty
  a_masked_latch: assert property (p_masked_latch)
    else $error("masked source reached the core");

  property p_hib_load;
    @(posedge clock_i) disable iff (!arst_n_i)
      (hib_write && bus_wdata_i != 8'h00) |=>
      hibernation_countdown == $past(bus_wdata_i) && !hibernation_wake_o;
  endproperty
  a_hib_load: assert property (p_hib_load)
    else $error("hibernation load failed");

  property p_hib_hold_zero;
    @(posedge clock_i) disable iff (!arst_n_i)
      (hibernation_countdown == 8'h00 && !hib_write) |=>
      hibernation_countdown == 8'h00 && !hibernation_wake_o;
  endproperty
  a_hib_hold_zero: assert property (p_hib_hold_zero)
    else $error("hibernation timer left zero on its own");

  property p_hib_expire;
    @(posedge clock_i) disable iff (!arst_n_i)
      (hibernation_countdown == 8'h01 && hib_step && !hib_write) |=>
      hibernation_wake_o && hibernation_countdown == 8'h00;
  endproperty
  a_hib_expire: assert property (p_hib_expire)
    else $error("hibernation expiry gave no wake event");

  property p_hib_zero_write;
    @(posedge clock_i) disable iff (!arst_n_i)
      (hib_write && bus_wdata_i == 8'h00) |=>
      (hibernation_countdown == 8'h00 && !hibernation_wake_o) ##1
      !hibernation_wake_o;
  endproperty
  a_hib_zero_write: assert property (p_hib_zero_write)
    else $error("zero write produced a wake event");

  property p_hib_step_only;
    @(posedge clock_i) disable iff (!arst_n_i)
      (!hib_write && !hib_step) |=> $stable(hibernation_countdown);
  endproperty
  a_hib_step_only: assert property (p_hib_step_only)
    else $error("hibernation count moved without a step");

  property p_pgi_set;
    @(posedge clock_i) disable iff (!arst_n_i)
      (power_ok_prev && !main_power_ok_input_i) |=>
      power_good_loss_flag_bit ##1 core_irq_o.power_fail;
  endproperty
  a_pgi_set: assert property (p_pgi_set)
    else $error("power loss not flagged to the core");

  property p_pgi_sticky;
    @(posedge clock_i) disable iff (!arst_n_i)
      (power_good_loss_flag_bit &&
       !(bus_write_i && hit(bus_addr_i, `WMEI_ADDR_PWR_IRQ) &&
         bus_wdata_i[`WMEI_PGI_BIT])) |=> power_good_loss_flag_bit;
  endproperty
  a_pgi_sticky: assert property (p_pgi_sticky)
    else $error("power loss flag cleared without a write of one");

  property p_pgi_rise_cause;
    @(posedge clock_i) disable iff (!arst_n_i)
      $rose(power_good_loss_flag_bit) |->
      !$past(main_power_ok_input_i) && $past(power_ok_prev);
  endproperty
  a_pgi_rise_cause: assert property (p_pgi_rise_cause)
    else $error("power loss flag set while power ok");

  property p_sirq_disabled;
    @(posedge clock_i) disable iff (!arst_n_i)
      !serial_irq_control[`WMEI_SIRQ_EN_BIT] |=>
      serial_irq_o.request_asserted;
  endproperty
  a_sirq_disabled: assert property (p_sirq_disabled)
    else $error("disabled mapping not at default asserted level");

  property p_sirq_mapped;
    @(posedge clock_i) disable iff (!arst_n_i)
      serial_irq_control[`WMEI_SIRQ_EN_BIT] |=>
      serial_irq_o.request_asserted ==
      ($past(serial_irq_control[`WMEI_SIRQ_REQ_BIT]) &&
       $past(serial_irq_control[`WMEI_SIRQ_SEL_MSB:`WMEI_SIRQ_SEL_LSB])
       != `WMEI_SIRQ_NONE);
  endproperty
  a_sirq_mapped: assert property (p_sirq_mapped)
    else $error("serial request does not follow request and select");

endmodule
`default_nettype wire

/* File: pkg/wmei_pkg.sv */
// Types shared by the wake and interrupt support logic.
package wmei_pkg;

  // Interrupt lines toward the embedded core.
  typedef struct packed {
    logic core_external_interrupt_two;
    logic core_external_interrupt_three;
    logic core_external_interrupt_four;
    logic power_fail;
  } wmei_core_irq_s;

  // Request presented to the host serial IRQ stream logic.
  typedef struct packed {
    logic [3:0] irq_select;
    logic       enabled;
    logic       request_asserted;
  } wmei_sirq_s;

endpackage

/* File: pkg/wmei_regs.svh */
// Register offsets, field positions, reset values and timing for wake logic.
`ifndef WMEI_REGS_SVH
`define WMEI_REGS_SVH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets in the core memory map.
`define WMEI_ADDR_SIRQ          16'h7F52
`define WMEI_ADDR_MASK_LPC      16'h7F56
`define WMEI_ADDR_ES0_LO        16'h7F57
`define WMEI_ADDR_ES0_HI        16'h7F58
`define WMEI_ADDR_ES1_LO        16'h7F5C
`define WMEI_ADDR_ES1_HI        16'h7F5D
`define WMEI_ADDR_SRC_G1        16'h7F5E
`define WMEI_ADDR_MASK_G1       16'h7F5F
`define WMEI_ADDR_ES2_LO        16'h7F61
`define WMEI_ADDR_ES2_HI        16'h7F62
`define WMEI_ADDR_SRC_G2        16'h7F63
`define WMEI_ADDR_MASK_MISC     16'h7F65
`define WMEI_ADDR_MASK_G2       16'h7F66
`define WMEI_ADDR_PWR_IRQ       16'h7F84
`define WMEI_ADDR_HIB           16'h7FF3

////////////////////////////////////////////////////////////////////////////
// Reset values and field layout.
`define WMEI_RESET_VALUE        8'h00
`define WMEI_MASK_MISC_WRITABLE 8'h07
`define WMEI_SIRQ_WRITABLE      8'hFC
`define WMEI_SIRQ_SEL_MSB       7
`define WMEI_SIRQ_SEL_LSB       4
`define WMEI_SIRQ_EN_BIT        3
`define WMEI_SIRQ_REQ_BIT       2
`define WMEI_SIRQ_NONE          4'h0
`define WMEI_PGI_BIT            0
`define WMEI_EDGE_FALL          2'h0
`define WMEI_EDGE_RISE          2'h1
`define WMEI_EDGE_EITHER        2'h2

////////////////////////////////////////////////////////////////////////////
// Hibernation timing: one count step in seconds, low-speed tick rate.
`define WMEI_HIB_STEP_SECONDS   30
`define WMEI_LOW_CLOCK_HZ       32768
`define WMEI_HIB_STEP_TICKS     (`WMEI_HIB_STEP_SECONDS * `WMEI_LOW_CLOCK_HZ)

`endif

/* File: verification/wmei_core_model.sv */
// Behavioural embedded core issuing register reads and writes.
`timescale 1ns/1ns
`default_nettype none

module wmei_core_model (
  // Clock and read data
  input  wire logic        clock_i,
  input  wire logic [7:0]  rdata_i,
  // Register strobes
  output logic      [15:0] addr_o,
  output logic      [7:0]  wdata_o,
  output logic             write_o,
  output logic             read_o
);
  initial begin
    addr_o  = 16'h0000;
    wdata_o = 8'h00;
    write_o = 1'b0;
    read_o  = 1'b0;
  end

  // Idle address and data are inverted so that no stale value can match.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock_i);
    addr_o  = a;
    wdata_o = d;
    write_o = 1'b1;
    @(negedge clock_i);
    write_o = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clock_i);
    addr_o = a;
    read_o = 1'b1;
    @(negedge clock_i);
    read_o = 1'b0;
    addr_o = ~a;
    d      = rdata_i;
  endtask
endmodule

`default_nettype wire

/* File: verification/wmei_top_tb.sv */
// Self-checking bench for the wake and interrupt support block.
`timescale 1ns/1ns
`default_nettype none
`include "wmei_regs.svh"

module wmei_top_tb;
  logic                     clock_i;
  logic                     arst_n_i;
  logic [15:0]              addr;
  logic [7:0]               wdata;
  logic                     write;
  logic                     read;
  logic [7:0]               rdata;
  logic [23:0]              src;
  logic                     tick;
  logic                     pok;
  logic [7:0]               pend0;
  logic                     hib_wake;
  logic [7:0]               m0   = 8'h00;
  logic [7:0]               c0   = 8'h00;
  logic [2:0]               misc = 3'h0;
  logic [7:0]               lpcf = 8'h00;
  logic                     wmisc;
  logic                     wlpc;
  wmei_pkg::wmei_core_irq_s core_irq;
  wmei_pkg::wmei_sirq_s     sirq;
  int                       n_errors = 0;
  int                       compares = 0;
  int                       cycles   = 0;
  int                       n_wake   = 0;
  logic [15:0]              rst_map [6] = '{`WMEI_ADDR_SIRQ,
    `WMEI_ADDR_ES0_LO, `WMEI_ADDR_MASK_G1, `WMEI_ADDR_PWR_IRQ,
    `WMEI_ADDR_HIB, 16'h7F00};
  logic [7:0]               sq_in  [4] = '{8'h5F, 8'h58, 8'h0C, 8'h53};
  logic [7:0]               sq_exp [4] = '{8'h17, 8'h16, 8'h02, 8'h15};

  wmei_core_model core_u (.clock_i(clock_i), .rdata_i(rdata),
    .addr_o(addr), .wdata_o(wdata), .write_o(write), .read_o(read));

  wmei_top #(.HIB_STEP_TICKS(2)) dut_u (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .bus_addr_i(addr), .bus_wdata_i(wdata),
    .bus_write_i(write), .bus_read_i(read), .bus_rdata_o(rdata),
    .selectable_source_i(src), .wake_mask_group0_i(m0),
    .wake_clear_group0_i(c0), .wake_pending_group0_o(pend0),
    .wake_misc_flags_i(misc), .wake_lpc_gpio_flags_i(lpcf),
    .wake_misc_o(wmisc), .wake_lpc_gpio_o(wlpc), .slow_clock_tick_i(tick),
    .hibernation_wake_o(hib_wake), .main_power_ok_input_i(pok),
    .core_irq_o(core_irq), .serial_irq_o(sirq));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles++;
    if (hib_wake === 1'b1) begin
      n_wake++;
    end
    if (cycles == 4000) begin
      n_errors++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    core_u.rd(a, d);
    chk(d, e);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge clock_i);
      tick = 1'b1;
      @(negedge clock_i);
      tick = 1'b0;
    end
  endtask

  task automatic close_out;
    if (n_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n_i = 1'b0;
    src      = 24'h000000;
    tick     = 1'b0;
    pok      = 1'b1;
    repeat (16) @(posedge clock_i);
    @(negedge clock_i);
    arst_n_i = 1'b1;
    @(negedge clock_i);
    chk(8'(sirq.request_asserted), 8'h01);
    foreach (rst_map[i]) rc(rst_map[i], 8'h00);
    // Rising edges must not latch while every field selects falling.
    src = 24'hFFFFFF;
    repeat (3) @(negedge clock_i);
    rc(`WMEI_ADDR_SRC_G1, 8'h00);
    src = 24'h000000;
    repeat (3) @(negedge clock_i);
    chk(8'(core_irq), 8'h0E);
    chk(pend0, 8'hFF);
    core_u.wr(`WMEI_ADDR_MASK_G1, 8'hFF);
    repeat (2) @(negedge clock_i);
    chk(8'(core_irq), 8'h0A);
    rc(`WMEI_ADDR_SRC_G1, 8'hFF);
    core_u.wr(`WMEI_ADDR_SRC_G2, 8'hFF);
    rc(`WMEI_ADDR_SRC_G2, 8'h00);
    core_u.wr(`WMEI_ADDR_ES2_LO, 8'h02);
    core_u.wr(`WMEI_ADDR_SRC_G2, 8'hFF);
    src[16] = 1'b1;
    rc(`WMEI_ADDR_SRC_G2, 8'h01);
    // Rise code on source 8, reserved code on source 11.
    core_u.wr(`WMEI_ADDR_SRC_G1, 8'hFF);
    core_u.wr(`WMEI_ADDR_ES1_LO, 8'hC1);
    @(negedge clock_i);
    src[15:8] = 8'h09;
    rc(`WMEI_ADDR_SRC_G1, 8'h01);
    core_u.wr(`WMEI_ADDR_ES1_LO, 8'h41);
    rc(`WMEI_ADDR_SRC_G1, 8'h09);
    // Hibernation timer with two ticks per step.
    core_u.wr(`WMEI_ADDR_HIB, 8'h03);
    rc(`WMEI_ADDR_HIB, 8'h03);
    ticks(2);
    rc(`WMEI_ADDR_HIB, 8'h02);
    ticks(6);
    rc(`WMEI_ADDR_HIB, 8'h00);
    chk(8'(n_wake), 8'h01);
    core_u.wr(`WMEI_ADDR_HIB, 8'h00);
    ticks(2);
    chk(8'(n_wake), 8'h01);
    // Power-good loss flag.
    pok = 1'b0;
    repeat (3) @(negedge clock_i);
    chk(8'(core_irq), 8'h0B);
    core_u.wr(`WMEI_ADDR_PWR_IRQ, 8'h00);
    rc(`WMEI_ADDR_PWR_IRQ, 8'h01);
    pok = 1'b1;
    core_u.wr(`WMEI_ADDR_PWR_IRQ, 8'h01);
    rc(`WMEI_ADDR_PWR_IRQ, 8'h00);
    // Masks for group zero, group two and the outside flag inputs.
    m0   = 8'hFF;
    misc = 3'h5;
    lpcf = 8'h81;
    core_u.wr(`WMEI_ADDR_MASK_G2, 8'h01);
    @(negedge clock_i);
    chk(8'(core_irq), 8'h00);
    rc(`WMEI_ADDR_SRC_G2, 8'h01);
    chk({6'h00, wmisc, wlpc}, 8'h03);
    core_u.wr(`WMEI_ADDR_MASK_MISC, 8'hFD);
    core_u.wr(`WMEI_ADDR_MASK_LPC, 8'h80);
    rc(`WMEI_ADDR_MASK_MISC, 8'h05);
    chk({6'h00, wmisc, wlpc}, 8'h01);
    c0 = 8'hFF;
    @(negedge clock_i);
    c0 = 8'h00;
    @(negedge clock_i);
    chk(pend0, 8'h00);
    // Serial IRQ mapping; firmware alone raises and lowers the request.
    foreach (sq_in[i]) begin
      core_u.wr(`WMEI_ADDR_SIRQ, sq_in[i]);
      @(negedge clock_i);
      chk(8'(sirq), sq_exp[i]);
    end
    rc(`WMEI_ADDR_SIRQ, 8'h50);
    close_out();
  end
endmodule

`default_nettype wire
